/* File: src/tx_status_pkg.sv */
// Operation
// - set deferred flag on first-attempt wait
// - descriptor status writeback clears deferred flag
// - carrier watched from delimiter to last byte
// - no-carrier flag set at preamble start
// - carrier seen in window clears no-carrier
// - loopback: no-carrier held while receive idle
// - carrier low in window sets carrier-lost
// - carrier flags never abort the packet
// - absent carrier reports both carrier flags
// - loopback always sets carrier-lost flag
// - sixteenth collision aborts, sets excessive flag
// - collision past slot time flags out-of-window
// - window origin: preamble or delimiter, selectable
// - out-of-window collision backs off, no abort
// - CRC checker active during own transmission
// - bad CRC, alignment, unknown source: monitored bad
// - CRC append inhibited holds monitored-bad low
package tx_status_pkg;

  // timing
  localparam real         CLK_FREQ_MHZ   = 100.0;   // core clock rate
  localparam real         SLOT_TIME_US   = 51.2;    // one slot time
  localparam int unsigned SLOT_CYCLES    = int'($floor(SLOT_TIME_US * CLK_FREQ_MHZ));
  localparam int unsigned SLOT_CNT_W     = 16;      // wide enough for the slot count

  // collision limit
  localparam int unsigned MAX_COLLISIONS = 16;
  localparam int unsigned COLL_CNT_W     = 5;

  // register byte addresses on the wishbone bus
  localparam int unsigned ADR_W          = 4;
  localparam logic [3:0]  ADDR_CONTROL    = 4'h0;
  localparam logic [3:0]  ADDR_FLAGS      = 4'h4;
  localparam logic [3:0]  ADDR_INT_STATUS = 4'h8;
  localparam logic [3:0]  ADDR_INT_MASK   = 4'hC;

  // control register fields
  localparam int unsigned CTRL_W          = 3;
  localparam int unsigned CTRL_LOOPBACK   = 0;       // mac loopback mode
  localparam int unsigned CTRL_ORIGIN     = 1;       // collision_window_origin_select
  localparam int unsigned CTRL_CRC_APPEND_INHIBIT       = 2;       // crc_append_inhibit
  localparam logic [2:0]  CONTROL_RESET   = 3'h0;

  // interrupt status / mask fields
  localparam int unsigned INT_W           = 4;
  localparam int unsigned INT_DONE        = 0;       // attempt finished or aborted
  localparam int unsigned INT_EXCESS      = 1;       // excessive collisions
  localparam int unsigned INT_OWC         = 2;       // out-of-window collision
  localparam int unsigned INT_CARRIER_LOST_FLAG        = 3;       // carrier lost
  localparam logic [3:0]  INT_RESET       = 4'h0;
  localparam logic [3:0]  MASK_RESET      = 4'h0;

  // flags of tx_descriptor_status_word, bit 0 is deferred
  typedef struct packed {
    logic monitored_bad;
    logic out_of_window;
    logic excess_coll;
    logic carrier_lost_flag;
    logic no_carrier_flag;
    logic deferred;
  } tx_flags_t;
  localparam int unsigned FLAGS_W     = 6;
  localparam logic [5:0]  FLAGS_RESET = 6'h00;

  // one-cycle event pulses from the transmit machinery
  typedef struct packed {
    logic attempt_start;   // first preamble bit of an attempt
    logic sfd;             // start of frame delimiter sent
    logic last_byte;       // last byte of the attempt sent
    logic collision;       // collision detected on this attempt
    logic status_written;  // status word stored in transmit_descriptor_area
    logic monitor_done;    // receive unit finished checking own packet
  } tx_events_t;

  // result of self-monitoring, valid with monitor_done
  typedef struct packed {
    logic crc_bad;
    logic align_err;
    logic sa_match;        // source hit in address_match_table
  } mon_result_t;

  // transmit attempt phases
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_PREAMBLE,
    PH_FRAME,
    PH_BACKOFF
  } tx_phase_t;

endpackage

/* File: src/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// three-stage synchroniser per bit; output follows once stages two and three agree
module pin_sync #(
  parameter int unsigned W = 2
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // asynchronous pins and their clean copies
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic s1;  // metastable stage, read only by s2
      logic s2;  // second stage
      logic s3;  // third stage

      // shift chain; first stage feeds nothing but the second
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
        end else begin
          s1 <= async_i[g];
          s2 <= s1;
          s3 <= s2;
        end
      end

      // accept a new level only when two settled stages agree
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          sync_o[g] <= 1'b0;
        end else if (s2 == s3) begin
          sync_o[g] <= s3;
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

/* File: src/tx_packet_status_flags.sv */
`timescale 1ns/1ps
`default_nettype none
// transmit-outcome flag logic with a wishbone register slave
module tx_packet_status_flags
  import tx_status_pkg::*;
#(
  parameter int unsigned SLOT_CYCLES_P = SLOT_CYCLES  // shorten for simulation
) (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // wishbone classic slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [ADR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  // pins from the encoder/decoder
  input  wire logic               crs_i,
  input  wire logic               rx_activity_i,
  // transmit machinery, same clock
  input  wire tx_events_t         tx_ev_i,
  input  wire logic               defer_i,
  input  wire mon_result_t        mon_i,
  // results
  output tx_flags_t               tx_descriptor_status_word_o,
  output logic                    abort_o,
  output logic                    backoff_o,
  output logic                    crc_check_enable_o,
  output logic                    irq_o
);

  // synchronised pins
  logic [1:0]            pins_s;          // {rx activity, carrier sense}
  logic                  crs_s;           // clean carrier sense
  logic                  rx_act_s;        // clean receive pair activity

  // software state
  logic [CTRL_W-1:0]     control;         // loopback, origin, crc inhibit
  logic [INT_W-1:0]      int_status;      // sticky event bits
  logic [INT_W-1:0]      int_mask;        // enables onto irq_o

  // transmit tracking
  tx_phase_t             phase;           // current attempt phase
  logic                  in_packet;       // between first attempt and completion
  logic [COLL_CNT_W-1:0] coll_count;      // collisions on this packet
  logic [SLOT_CNT_W-1:0] slot_count;      // time since window origin
  logic                  slot_run;        // slot timer counting
  tx_flags_t             flags;           // status word under construction

  // decoded helpers
  logic                  loopback;
  logic                  origin_sfd;
  logic                  crc_inhibit;
  logic                  first_attempt;   // attempt_start of a new packet
  logic                  coll_valid;      // collision during a live attempt
  logic                  coll_last;       // this collision is the sixteenth
  logic                  late_coll;       // collision beyond one slot
  logic                  in_window;       // carrier monitoring window
  logic                  carrier_seen;    // carrier evidence in window
  logic                  mon_bad;         // self-monitor verdict
  logic [INT_W-1:0]      int_events;      // this cycle's interrupt causes
  logic                  wb_req;          // new bus request this cycle
  logic                  wb_wr;           // write taken this cycle
  logic [31:0]           next_dat;        // read mux

  // pins cross into the clock domain through three stages
  pin_sync #(
    .W (2)
  ) u_pin_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i ({rx_activity_i, crs_i}),
    .sync_o  (pins_s)
  );

  assign crs_s    = pins_s[0];
  assign rx_act_s = pins_s[1];

  assign loopback    = control[CTRL_LOOPBACK];
  assign origin_sfd  = control[CTRL_ORIGIN];
  assign crc_inhibit = control[CTRL_CRC_APPEND_INHIBIT];

  // event qualification
  assign first_attempt = tx_ev_i.attempt_start && !in_packet;
  assign coll_valid    = tx_ev_i.collision &&
                         (phase == PH_PREAMBLE || phase == PH_FRAME);
  // count reaching sixteen with this hit
  assign coll_last     = coll_valid &&
                         (coll_count == COLL_CNT_W'(MAX_COLLISIONS - 1));
  // compare against the slot time from whichever origin is selected
  assign late_coll     = coll_valid && slot_run &&
                         (slot_count >= SLOT_CNT_W'(SLOT_CYCLES_P));

  // window runs from the delimiter to the last byte
  assign in_window = (phase == PH_FRAME);
  // in loopback the carrier evidence is activity on the receive pair
  assign carrier_seen = loopback ? rx_act_s : crs_s;

  // any monitor failure counts, unless the frame carries no crc
  assign mon_bad = !crc_inhibit &&
                   (mon_i.crc_bad || mon_i.align_err || !mon_i.sa_match);

  // attempt phase machine
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase <= PH_IDLE;
    end else begin
      case (phase)
        PH_IDLE: begin
          if (tx_ev_i.attempt_start) begin
            phase <= PH_PREAMBLE;
          end
        end
        PH_PREAMBLE: begin
          if (coll_valid) begin
            phase <= coll_last ? PH_IDLE : PH_BACKOFF;
          end else if (tx_ev_i.sfd) begin
            phase <= PH_FRAME;
          end
        end
        PH_FRAME: begin
          // carrier trouble never ends the attempt early
          if (coll_valid) begin
            phase <= coll_last ? PH_IDLE : PH_BACKOFF;
          end else if (tx_ev_i.last_byte) begin
            phase <= PH_IDLE;
          end
        end
        PH_BACKOFF: begin
          // a late collision waits here just like an early one
          if (tx_ev_i.attempt_start) begin
            phase <= PH_PREAMBLE;
          end
        end
        default: begin
          phase <= PH_IDLE;
        end
      endcase
    end
  end

  // packet membership spans all retries
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_packet <= 1'b0;
    end else if (coll_last) begin
      in_packet <= 1'b0;
    end else if (phase == PH_FRAME && tx_ev_i.last_byte && !coll_valid) begin
      in_packet <= 1'b0;
    end else if (tx_ev_i.attempt_start) begin
      in_packet <= 1'b1;
    end
  end

  // collisions per packet, restarted by a new packet
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      coll_count <= '0;
    end else if (first_attempt) begin
      coll_count <= '0;
    end else if (coll_valid && !coll_last) begin
      coll_count <= coll_count + COLL_CNT_W'(1);
    end
  end

  // slot timer starts at preamble or delimiter, saturates, stops at idle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slot_run   <= 1'b0;
      slot_count <= '0;
    end else if (origin_sfd ? tx_ev_i.sfd : tx_ev_i.attempt_start) begin
      slot_run   <= 1'b1;
      slot_count <= '0;
    end else if (coll_valid || phase == PH_IDLE || phase == PH_BACKOFF) begin
      slot_run   <= 1'b0;
      slot_count <= '0;
    end else if (slot_run && slot_count != '1) begin
      slot_count <= slot_count + SLOT_CNT_W'(1);
    end
  end

  // deferred: waited before the first attempt, dropped on later collisions
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags.deferred <= 1'b0;
    end else if (defer_i && !in_packet) begin
      flags.deferred <= 1'b1;
    end else if (coll_valid) begin
      flags.deferred <= 1'b0;
    end else if (tx_ev_i.status_written) begin
      flags.deferred <= 1'b0;
    end
  end

  // no carrier: armed at preamble, cleared by carrier in the window
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags.no_carrier_flag <= 1'b0;
    end else if (tx_ev_i.attempt_start) begin
      flags.no_carrier_flag <= 1'b1;
    end else if (in_window && carrier_seen) begin
      flags.no_carrier_flag <= 1'b0;
    end else if (tx_ev_i.status_written) begin
      flags.no_carrier_flag <= 1'b0;
    end
  end

  // carrier lost: any low sample in the window, always in loopback
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags.carrier_lost_flag <= 1'b0;
    end else if (loopback && tx_ev_i.attempt_start) begin
      flags.carrier_lost_flag <= 1'b1;
    end else if (in_window && !crs_s) begin
      // never-seen carrier lands here too, next to no-carrier
      flags.carrier_lost_flag <= 1'b1;
    end else if (tx_ev_i.status_written) begin
      flags.carrier_lost_flag <= 1'b0;
    end
  end

  // excessive collisions
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags.excess_coll <= 1'b0;
    end else if (coll_last) begin
      flags.excess_coll <= 1'b1;
    end else if (tx_ev_i.status_written) begin
      flags.excess_coll <= 1'b0;
    end
  end

  // out-of-window collision; a same-cycle writeback loses to the set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags.out_of_window <= 1'b0;
    end else if (late_coll) begin
      flags.out_of_window <= 1'b1;
    end else if (tx_ev_i.status_written) begin
      flags.out_of_window <= 1'b0;
    end
  end

  // monitored bad, held low whenever crc append is inhibited
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags.monitored_bad <= 1'b0;
    end else if (crc_inhibit) begin
      flags.monitored_bad <= 1'b0;
    end else if (tx_ev_i.monitor_done && mon_bad) begin
      flags.monitored_bad <= 1'b1;
    end else if (tx_ev_i.status_written) begin
      flags.monitored_bad <= 1'b0;
    end
  end

  // status word copy handed to the descriptor writer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_descriptor_status_word_o <= tx_flags_t'(FLAGS_RESET);
    end else begin
      tx_descriptor_status_word_o <= flags;
    end
  end

  // abort and backoff requests to the transmitter, one cycle each
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      abort_o   <= 1'b0;
      backoff_o <= 1'b0;
    end else begin
      abort_o   <= coll_last;
      backoff_o <= coll_valid && !coll_last;
    end
  end

  // receive-side checker follows our own packet
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      crc_check_enable_o <= 1'b0;
    end else begin
      crc_check_enable_o <= in_packet || tx_ev_i.attempt_start;
    end
  end

  // interrupt causes
  assign int_events[INT_DONE]   = coll_last ||
                                  (phase == PH_FRAME && tx_ev_i.last_byte && !coll_valid);
  assign int_events[INT_EXCESS] = coll_last;
  assign int_events[INT_OWC]    = late_coll;
  assign int_events[INT_CARRIER_LOST_FLAG]   = in_window && !crs_s;

  // bus decode; ack drops the cycle after it is given
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr  = wb_req && wb_we_i && wb_sel_i[0];

  // control register, low byte lane only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      control <= CONTROL_RESET;
    end else if (wb_wr && wb_adr_i == ADDR_CONTROL) begin
      control <= wb_dat_i[CTRL_W-1:0];
    end
  end

  // mask register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_mask <= MASK_RESET;
    end else if (wb_wr && wb_adr_i == ADDR_INT_MASK) begin
      int_mask <= wb_dat_i[INT_W-1:0];
    end
  end

  // sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_status <= INT_RESET;
    end else if (wb_wr && wb_adr_i == ADDR_INT_STATUS) begin
      int_status <= (int_status & ~wb_dat_i[INT_W-1:0]) | int_events;
    end else begin
      int_status <= int_status | int_events;
    end
  end

  // level interrupt while any unmasked bit stands
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(int_status & int_mask);
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    next_dat = 32'h0000_0000;
    case (wb_adr_i)
      ADDR_CONTROL:    next_dat[CTRL_W-1:0]  = control;
      ADDR_FLAGS:      next_dat[FLAGS_W-1:0] = flags;
      ADDR_INT_STATUS: next_dat[INT_W-1:0]   = int_status;
      ADDR_INT_MASK:   next_dat[INT_W-1:0]   = int_mask;
      default:         next_dat              = 32'h0000_0000;
    endcase
  end

  // single-wait-state answer for every address, mapped or not
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        wb_dat_o <= next_dat;
      end
    end
  end

endmodule
`default_nettype wire

/* File: sim/tx_packet_status_flags_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// passive checker on the ports of the transmit flag block
module tx_flags_monitor
  import tx_status_pkg::*;
#(
  parameter int unsigned SLOT_CYCLES_P = SLOT_CYCLES  // same slot count as the block
) (
  // clock and reset
  input wire logic             clk_i,
  input wire logic             rst_i,
  // wishbone side
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0]       wb_sel_i,
  input wire logic [31:0]      wb_dat_i,
  input wire logic [31:0]      wb_dat_o,
  input wire logic             wb_ack_o,
  // medium pins and transmit machinery
  input wire logic             crs_i,
  input wire logic             rx_activity_i,
  input wire tx_events_t       tx_ev_i,
  input wire logic             defer_i,
  input wire mon_result_t      mon_i,
  // results
  input wire tx_flags_t        tx_descriptor_status_word_o,
  input wire logic             abort_o,
  input wire logic             backoff_o,
  input wire logic             crc_check_enable_o,
  input wire logic             irq_o
);
  // one clock domain, so one clocking and one reset for all
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // status word trails the internal flags by one edge
  a_abort_excess: assert property (abort_o |=> tx_descriptor_status_word_o.excess_coll)
    else $error("abort without excessive-collision flag");
  a_abort_cause: assert property (abort_o |-> $past(tx_ev_i.collision))
    else $error("abort not caused by a collision");
  a_backoff_only: assert property (backoff_o |-> $past(tx_ev_i.collision) && !abort_o)
    else $error("backoff without collision or together with abort");
  a_crc_monitor: assert property (tx_ev_i.attempt_start |=> crc_check_enable_o)
    else $error("crc checker idle during own transmission");
  a_nocrs_arm: assert property (tx_ev_i.attempt_start |-> ##2
    tx_descriptor_status_word_o.no_carrier_flag)
    else $error("no-carrier flag not armed at preamble");
  a_both_carrier: assert property (tx_ev_i.last_byte |-> ##2
    (!tx_descriptor_status_word_o.no_carrier_flag ||
     tx_descriptor_status_word_o.carrier_lost_flag))
    else $error("absent carrier reported without carrier-lost");
  a_status_clear: assert property ((tx_ev_i == tx_events_t'(6'h02)) && !defer_i |-> ##2
    (tx_descriptor_status_word_o == tx_flags_t'(FLAGS_RESET)))
    else $error("flags not cleared by status writeback");
  a_defer_set: assert property (defer_i && !crc_check_enable_o &&
    (tx_ev_i == tx_events_t'(6'h00)) |-> ##2 tx_descriptor_status_word_o.deferred)
    else $error("deferred flag not set while waiting for medium");
  a_defer_drop: assert property (tx_ev_i.collision && crc_check_enable_o |-> ##2
    !tx_descriptor_status_word_o.deferred)
    else $error("deferred flag kept after a collision");
endmodule

bind tx_packet_status_flags tx_flags_monitor #(.SLOT_CYCLES_P(SLOT_CYCLES_P)) u_mon (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .crs_i(crs_i), .rx_activity_i(rx_activity_i),
  .tx_ev_i(tx_ev_i), .defer_i(defer_i), .mon_i(mon_i),
  .tx_descriptor_status_word_o(tx_descriptor_status_word_o), .abort_o(abort_o),
  .backoff_o(backoff_o), .crc_check_enable_o(crc_check_enable_o), .irq_o(irq_o));
`default_nettype wire

/* File: sim/medium_model.sv */
`timescale 1ns/1ps
`default_nettype none
// behavioural medium: carrier sense as seen through the encoder/decoder
module medium_model
  import tx_status_pkg::*;
(
  // clock and transmit events
  input  wire logic       clk_i,
  input  wire tx_events_t tx_ev_i,
  // carrier mode: 0 follows frame, 1 never, 2 drops mid-frame
  input  wire logic [1:0] mode_i,
  input  wire logic       loop_act_i,
  // pins toward the block
  output logic            crs_o,
  output logic            rx_act_o
);
  int unsigned age = 100;  // cycles since the delimiter
  initial crs_o = 1'b0;
  // carrier rises with the preamble and falls at frame end or collision
  always @(posedge clk_i) begin
    age <= tx_ev_i.attempt_start ? 100 : (tx_ev_i.sfd ? 0 : age + 1);
    if (tx_ev_i.attempt_start) begin
      crs_o <= (mode_i != 2'd1);
    end else if (tx_ev_i.last_byte || tx_ev_i.collision) begin
      crs_o <= 1'b0;  // idle medium, no pull-up, so low
    end else if (mode_i == 2'd2 && age == 5) begin
      crs_o <= 1'b0;  // carrier lost inside the watched window
    end
  end
  // receive pair only busy when the bench asks for it
  assign rx_act_o = crs_o & loop_act_i;
endmodule
`default_nettype wire

/* File: sim/tb_tx_packet_status_flags.sv */
`timescale 1ns/1ps
`default_nettype none
// self-checking bench for the transmit flag block
module tb_tx_packet_status_flags import tx_status_pkg::*;;
  localparam int unsigned SLOT = 20;  // short slot time keeps the run brief
  localparam logic [5:0] EV_ATT = 6'h20, EV_SFD = 6'h10, EV_END = 6'h08;
  localparam logic [5:0] EV_COL = 6'h04, EV_WB = 6'h02, EV_MON = 6'h01;
  logic        clk_i, rst_i, cyc, stb, we, ack, defer, loop_act, crs, rx_act;
  logic        abort, backoff, crc_en, irq;
  logic [3:0]  adr, sel;
  logic [31:0] wdat, rdat, q;
  logic [1:0]  mode;
  tx_events_t  ev;
  mon_result_t mon;
  tx_flags_t   st;
  int          failures = 0;
  int          checks = 0;
  int          i;

  tx_packet_status_flags #(.SLOT_CYCLES_P(SLOT)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .crs_i(crs), .rx_activity_i(rx_act), .tx_ev_i(ev), .defer_i(defer), .mon_i(mon),
    .tx_descriptor_status_word_o(st), .abort_o(abort), .backoff_o(backoff),
    .crc_check_enable_o(crc_en), .irq_o(irq));
  medium_model u_medium (.clk_i(clk_i), .tx_ev_i(ev), .mode_i(mode),
    .loop_act_i(loop_act), .crs_o(crs), .rx_act_o(rx_act));

  // 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // one classic bus cycle; waits for ack, only the watchdog bounds a hang
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // compare one value, count and report
  task automatic check(input string s, input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic rdc(input logic [3:0] a, input logic [31:0] e, input string s);
    wb(1'b0, a, 32'h0, q);
    check(s, q, e);
  endtask

  // one-cycle event; waits an edge first so no double drive
  task automatic pulse(input logic [5:0] v);
    @(posedge clk_i);
    ev <= tx_events_t'(v);
    @(posedge clk_i);
    ev <= tx_events_t'(6'h00);
  endtask

  // one attempt: optional wait, preamble, frame, end or collision, writeback
  task automatic pkt(input logic d, input logic [1:0] m, input logic [2:0] r,
                     input logic [5:0] e, input logic c);
    mode <= m;
    mon <= mon_result_t'(r);
    defer <= d;
    repeat (3) @(posedge clk_i);
    defer <= 1'b0;
    pulse(EV_ATT);
    repeat (4) @(posedge clk_i);
    check("crc check", {31'h0, crc_en}, 32'h1);
    pulse(EV_SFD);
    repeat (15) @(posedge clk_i);
    if (c) begin
      pulse(EV_COL);
      @(posedge clk_i);
      check("backoff", {31'h0, backoff}, 32'h1);
    end else begin
      pulse(EV_END);
      pulse(EV_MON);
    end
    repeat (3) @(posedge clk_i);
    check("status word", {26'h0, st}, {26'h0, e});
    rdc(ADDR_FLAGS, {26'h0, e}, "flags reg");
    pulse(EV_WB);
    repeat (2) @(posedge clk_i);
    check("cleared", {26'h0, st}, 32'h0);
  endtask

  task automatic test_done;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // hang guard, far beyond the expected several hundred cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    test_done();
  end

  // main sequence
  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, defer, loop_act} = 5'h00;
    adr = 4'h0;
    sel = 4'hF;
    wdat = 32'h0;
    mode = 2'd0;
    ev = tx_events_t'(6'h00);
    mon = mon_result_t'(3'h1);
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values, read-only and unmapped places
    for (i = 0; i < 4; i++) rdc(4'(4 * i), 32'h0, "reset value");
    wb(1'b1, ADDR_FLAGS, 32'h3F, q);
    wb(1'b1, 4'h2, 32'hFF, q);
    rdc(ADDR_FLAGS, 32'h0, "read-only flags");
    rdc(4'h2, 32'h0, "unmapped");
    wb(1'b1, ADDR_CONTROL, 32'h7, q);
    rdc(ADDR_CONTROL, 32'h7, "control");
    wb(1'b1, ADDR_CONTROL, 32'h0, q);
    // carrier cases and self-check faults
    pkt(1'b1, 2'd0, 3'b001, 6'h01, 1'b0);
    pkt(1'b0, 2'd1, 3'b001, 6'h06, 1'b0);
    pkt(1'b0, 2'd2, 3'b001, 6'h04, 1'b0);
    pkt(1'b0, 2'd0, 3'b101, 6'h20, 1'b0);
    pkt(1'b0, 2'd0, 3'b011, 6'h20, 1'b0);
    pkt(1'b0, 2'd0, 3'b000, 6'h20, 1'b0);
    // crc append inhibited hides the faults
    wb(1'b1, ADDR_CONTROL, 32'h4, q);
    pkt(1'b0, 2'd0, 3'b101, 6'h00, 1'b0);
    pkt(1'b0, 2'd0, 3'b010, 6'h00, 1'b0);
    // loopback with and without receive activity
    wb(1'b1, ADDR_CONTROL, 32'h1, q);
    pkt(1'b0, 2'd0, 3'b001, 6'h06, 1'b0);
    loop_act <= 1'b1;
    pkt(1'b0, 2'd0, 3'b001, 6'h04, 1'b0);
    loop_act <= 1'b0;
    // collision 23 cycles after preamble, 17 after delimiter
    wb(1'b1, ADDR_CONTROL, 32'h0, q);
    pkt(1'b0, 2'd0, 3'b001, 6'h10, 1'b1);
    wb(1'b1, ADDR_CONTROL, 32'h2, q);
    pkt(1'b0, 2'd0, 3'b001, 6'h00, 1'b1);
    // a clean retry ends the packet, so the next one starts afresh
    pkt(1'b0, 2'd0, 3'b001, 6'h00, 1'b0);
    rdc(ADDR_INT_STATUS, 32'hD, "int before clear");
    // sixteen collisions after a deferral
    wb(1'b1, ADDR_INT_STATUS, 32'hF, q);
    defer <= 1'b1;
    repeat (3) @(posedge clk_i);
    defer <= 1'b0;
    for (i = 1; i <= 16; i++) begin
      pulse(EV_ATT);
      pulse(EV_COL);
      @(posedge clk_i);
      check("retry", {30'h0, abort, backoff}, (i == 16) ? 32'h2 : 32'h1);
      @(posedge clk_i);
      if (i == 1) check("deferred", {31'h0, st.deferred}, 32'h0);
    end
    @(posedge clk_i);
    check("excess", {26'h0, st}, 32'h0A);
    // sticky events, mask and write-one-to-clear
    rdc(ADDR_INT_STATUS, 32'h3, "int status");
    check("irq masked", {31'h0, irq}, 32'h0);
    wb(1'b1, ADDR_INT_MASK, 32'h2, q);
    repeat (2) @(posedge clk_i);
    check("irq raised", {31'h0, irq}, 32'h1);
    wb(1'b1, ADDR_INT_STATUS, 32'h2, q);
    repeat (2) @(posedge clk_i);
    check("irq cleared", {31'h0, irq}, 32'h0);
    rdc(ADDR_INT_STATUS, 32'h1, "int after clear");
    test_done();
  end
endmodule
`default_nettype wire
